//--- pcs_bcd_step.sv
`timescale 1ns/100ps
`default_nettype none

// one bcd field step: advance, or wrap to low once top is reached
module pcs_bcd_step (
   input wire logic [7:0] value_i,
   input wire logic [7:0] top_i,
   input wire logic [7:0] low_i,
   output logic [7:0] next_o,
   output logic wrap_o
);

   // a field already past top also wraps, so a bad load recovers
   always_comb begin
      wrap_o = 1'h0;
      if (value_i >= top_i) begin
         next_o = low_i;
         wrap_o = 1'h1;
      end else if (value_i[3:0] >= 4'h9) begin
         next_o = {value_i[7:4] + 4'h1, 4'h0};
      end else begin
         next_o = {value_i[7:4], value_i[3:0] + 4'h1};
      end
   end

endmodule

`default_nettype wire

//--- pcs_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the socket: plain sram cycles, one at a time
module pcs_host (
   input wire logic clk_i,
   input wire logic sd_i,
   input wire logic sd_oe_i,
   input wire logic mce_n_i,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic bus_o
);
   logic hd_q = 1'b0;
   logic hen_q = 1'b0;
   // memory enable seen during the last write strobe
   logic wm_q = 1'b0;
   initial begin
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
   end
   // a released line shows the inverse of the last value, never a stale copy
   assign bus_o = sd_oe_i ? sd_i : (hen_q ? hd_q : ~hd_q);
   task automatic wr(input logic b);
      @(posedge clk_i);
      #1;
      ce_n_o = 1'b0;
      we_n_o = 1'b0;
      hd_q = b;
      hen_q = 1'b1;
      @(posedge clk_i);
      #1;
      wm_q = mce_n_i;
      ce_n_o = 1'b1;
      we_n_o = 1'b1;
      hen_q = 1'b0;
   endtask
   // strobe low two cycles so the driven bit is seen held, answer taken after the second edge
   task automatic rd(input logic ce, output logic q, output logic oe, output logic m);
      @(posedge clk_i);
      #1;
      ce_n_o = ce;
      oe_n_o = 1'b0;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
      q = sd_i;
      oe = sd_oe_i;
      m = mce_n_i;
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
   endtask
   // arming read, pattern lsb first, one cycle with the socket off
   task automatic unlock(input int n, input int bad);
      logic q, oe, m;
      rd(1'b0, q, oe, m);
      for (int i = 0; i < n; i++) begin
         if (i == 5) rd(1'b1, q, oe, m);
         wr(pcs_pkg::UNLOCK_PATTERN[i] ^ (i == bad));
      end
   endtask
endmodule
`default_nettype wire

//--- pcs_pkg.sv
package pcs_pkg;

   // host bus timing and the hundredths tick
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned HUND_PERIOD_NS = 10000000;
   localparam int unsigned HUND_CYCLES_DFLT = HUND_PERIOD_NS / CLK_PERIOD_NS;

   // serial stream lengths
   localparam int unsigned STREAM_BITS = 64;
   localparam logic [5:0] STREAM_LAST = 6'h3F;
   localparam logic [5:0] STREAM_FIRST = 6'h00;

   // unlock pattern, bit i is the i-th bit sent (C5 3A A3 5C C5 3A A3 5C, lsb first)
   localparam logic [63:0] UNLOCK_PATTERN = 64'h5CA33AC55CA33AC5;

   // timekeeping register indices
   localparam int unsigned REG_HUND = 0;
   localparam int unsigned REG_SEC = 1;
   localparam int unsigned REG_MIN = 2;
   localparam int unsigned REG_HOUR = 3;
   localparam int unsigned REG_WEEK = 4;
   localparam int unsigned REG_DATE = 5;
   localparam int unsigned REG_MONTH = 6;
   localparam int unsigned REG_YEAR = 7;
   localparam int unsigned REG_COUNT = 8;

   // field positions
   localparam int unsigned HOUR_MODE_BIT = 7;
   localparam int unsigned HOUR_PM_BIT = 5;
   localparam int unsigned WEEK_RSTGATE_BIT = 4;
   localparam int unsigned WEEK_OSCOFF_BIT = 5;

   // implemented bits per register, byte 7 first; the others read zero
   localparam logic [63:0] REG_MASK = 64'hFF1F3F37BF7F7FFF;
   // reset contents: 01-01-00, weekday 1, gate and oscillator-off bits set
   localparam logic [63:0] REG_RESET = 64'h0001013100000000;

   // bcd limits
   localparam logic [7:0] BCD_00 = 8'h00;
   localparam logic [7:0] BCD_01 = 8'h01;
   localparam logic [7:0] BCD_02 = 8'h02;
   localparam logic [7:0] BCD_04 = 8'h04;
   localparam logic [7:0] BCD_06 = 8'h06;
   localparam logic [7:0] BCD_07 = 8'h07;
   localparam logic [7:0] BCD_09 = 8'h09;
   localparam logic [7:0] BCD_11 = 8'h11;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_28 = 8'h28;
   localparam logic [7:0] BCD_29 = 8'h29;
   localparam logic [7:0] BCD_30 = 8'h30;
   localparam logic [7:0] BCD_31 = 8'h31;
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_99 = 8'h99;

   // access sequencer states
   typedef enum logic [3:0] {
      PCS_ST_IDLE = 4'h1,
      PCS_ST_MATCH = 4'h2,
      PCS_ST_MISS = 4'h4,
      PCS_ST_XFER = 4'h8
   } pcs_state_e;

endpackage

//--- pcs_top.sv
`timescale 1ns/100ps
`default_nettype none

// Function
// - 64 writes on data bit 0 are compared against the comparison register.
// - before full recognition every access goes to the mated memory.
// - after recognition next 64 cycles reach the clock, memory inhibited.
// - a read cycle arms the pointer at the first pattern bit.
// - a matching unlock write advances the pointer.
// - a mismatch freezes the pointer; later writes ignored until a read.
// - a read during recognition aborts and rewinds the pointer.
// - unlock writes still reach memory; host keeps one scratch address.
// - pattern is C5 3A A3 5C C5 3A A3 5C, each byte lsb first.
// - transfer cycles drive data bit 0 on reads, capture it on writes.
// - cycles with socket chip enable inactive disturb nothing.
// - supply below threshold forces memory chip enable inactive, blocks clock writes.
// - with good supply and no transfer, memory chip enable follows socket chip enable.
// - transfer walks eight registers, bit 0 of reg 0 to bit 7 of reg 7.
// - all timekeeping contents are binary coded decimal.
// - hours bit 7 high selects 12-hour, low selects 24-hour.
// - hours bit 5 is pm in 12-hour mode, tens-of-twenty in 24-hour.
// - weekday bit 4 low lets reset pin low abort a transfer.
// - weekday bit 5 high stops the oscillator, low runs it.
// - reset gate and oscillator bits are both one after reset.
// - counts hundredths, seconds, minutes, hours, weekday, date, month, year.
// - date rolls at true month end with leap february through 2099.
// - unused bits in registers 1 to 6 read zero, writes accepted.
module pcs_top #(
   parameter int unsigned HUND_CYCLES = pcs_pkg::HUND_CYCLES_DFLT
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic serial_data_bit_i,
   input wire logic reset_n_i,
   input wire logic power_fail_i,
   output logic serial_data_bit_o,
   output logic serial_data_bit_oe_o,
   output logic mem_ce_n_o
);

   localparam int unsigned PW = $clog2(HUND_CYCLES);

   // the prescaler needs at least two states to make a tick
   if (HUND_CYCLES < 2) begin : g_bad_hund
      $error("HUND_CYCLES must be at least 2");
   end

   pcs_pkg::pcs_state_e state_q, state_d;
   logic [5:0] ptr_q, ptr_d;
   logic [5:0] bit_q, bit_d;
   logic [63:0] shadow_q, shadow_d;
   logic dirty_q, dirty_d;
   logic load_q, load_d;
   logic rd_act_q, rd_act_d;
   logic wr_act_q, wr_act_d;
   logic dq_q, dq_d;
   logic dq_out_q, dq_out_d;
   logic dq_oe_q, dq_oe_d;
   logic mem_ce_n_q, mem_ce_n_d;
   logic [7:0] t_q [pcs_pkg::REG_COUNT];
   logic [7:0] t_d [pcs_pkg::REG_COUNT];
   logic [PW-1:0] cnt_q, cnt_d;
   logic [63:0] time_w;
   logic rd_now, wr_now, rd_end, wr_end, xfer_abort;
   logic running, tick;
   logic [7:0] dim;
   logic leap;
   logic [7:0] hund_n, sec_n, min_n, h24_n, h12_n, wk_n, date_n, mon_n, yr_n;
   logic hund_w, sec_w, min_w, h24_w, h12_w, wk_w, date_w, mon_w, yr_w;

   // socket cycle qualifiers; a power fail blocks every cycle to the clock
   // ignore deselected
   always_comb begin
      rd_now = !power_fail_i && !ce_n_i && !oe_n_i && we_n_i;
      wr_now = !power_fail_i && !ce_n_i && !we_n_i;
      rd_end = rd_act_q && !rd_now;
      wr_end = wr_act_q && !wr_now;
   end

   // flat view of the time registers, also the snapshot source
   always_comb begin
      time_w = 64'h0;
      for (int i = 0; i < pcs_pkg::REG_COUNT; i++) begin
         time_w[i*8 +: 8] = t_q[i];
      end
   end

   assign xfer_abort = !reset_n_i && !t_q[pcs_pkg::REG_WEEK][pcs_pkg::WEEK_RSTGATE_BIT];

   // access sequencer; a cycle counts once, at the end of its strobe
   always_comb begin
      state_d = state_q;
      ptr_d = ptr_q;
      bit_d = bit_q;
      shadow_d = shadow_q;
      dirty_d = dirty_q;
      load_d = 1'h0;
      rd_act_d = rd_now;
      wr_act_d = wr_now;
      // data is sampled while the write strobe is low, used at its end
      dq_d = wr_now ? serial_data_bit_i : dq_q;
      case (state_q)
         pcs_pkg::PCS_ST_IDLE: begin
            if (rd_end) begin
               state_d = pcs_pkg::PCS_ST_MATCH;
               ptr_d = pcs_pkg::STREAM_FIRST;
            end
         end
         pcs_pkg::PCS_ST_MATCH: begin
            if (rd_end) begin
               ptr_d = pcs_pkg::STREAM_FIRST;
            end else if (wr_end) begin
               if (dq_q == pcs_pkg::UNLOCK_PATTERN[ptr_q]) begin
                  if (ptr_q == pcs_pkg::STREAM_LAST) begin
                     state_d = pcs_pkg::PCS_ST_XFER;
                     bit_d = pcs_pkg::STREAM_FIRST;
                     shadow_d = time_w;
                     dirty_d = 1'h0;
                  end else begin
                     ptr_d = ptr_q + 6'h01;
                  end
               end else begin
                  state_d = pcs_pkg::PCS_ST_MISS;
               end
            end
         end
         pcs_pkg::PCS_ST_MISS: begin
            if (rd_end) begin
               state_d = pcs_pkg::PCS_ST_MATCH;
               ptr_d = pcs_pkg::STREAM_FIRST;
            end
         end
         pcs_pkg::PCS_ST_XFER: begin
            if (xfer_abort) begin
               state_d = pcs_pkg::PCS_ST_IDLE;
               dirty_d = 1'h0;
            end else if (rd_end || wr_end) begin
               if (wr_end) begin
                  shadow_d[bit_q] = dq_q;
                  dirty_d = 1'h1;
               end
               bit_d = bit_q + 6'h01;
               if (bit_q == pcs_pkg::STREAM_LAST) begin
                  state_d = pcs_pkg::PCS_ST_IDLE;
                  load_d = dirty_q || wr_end;
                  dirty_d = 1'h0;
               end
            end
         end
         default: begin
            state_d = pcs_pkg::PCS_ST_IDLE;
         end
      endcase
   end

   // pin drivers, registered so every output leaves a flip-flop
   always_comb begin
      dq_oe_d = (state_q == pcs_pkg::PCS_ST_XFER) && rd_now && !xfer_abort;
      dq_out_d = shadow_q[bit_q];
      mem_ce_n_d = power_fail_i || ce_n_i || (state_q == pcs_pkg::PCS_ST_XFER);
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= pcs_pkg::PCS_ST_IDLE;
         ptr_q <= 6'h00;
         bit_q <= 6'h00;
         shadow_q <= 64'h0;
         dirty_q <= 1'h0;
         load_q <= 1'h0;
         rd_act_q <= 1'h0;
         wr_act_q <= 1'h0;
         dq_q <= 1'h0;
         dq_out_q <= 1'h0;
         dq_oe_q <= 1'h0;
         mem_ce_n_q <= 1'h1;
      end else begin
         state_q <= state_d;
         ptr_q <= ptr_d;
         bit_q <= bit_d;
         shadow_q <= shadow_d;
         dirty_q <= dirty_d;
         load_q <= load_d;
         rd_act_q <= rd_act_d;
         wr_act_q <= wr_act_d;
         dq_q <= dq_d;
         dq_out_q <= dq_out_d;
         dq_oe_q <= dq_oe_d;
         mem_ce_n_q <= mem_ce_n_d;
      end
   end

   assign serial_data_bit_o = dq_out_q;
   assign serial_data_bit_oe_o = dq_oe_q;
   assign mem_ce_n_o = mem_ce_n_q;

   // hundredths prescaler; held cleared while the oscillator is stopped
   // oscillator control
   always_comb begin
      running = !t_q[pcs_pkg::REG_WEEK][pcs_pkg::WEEK_OSCOFF_BIT];
      tick = running && (cnt_q == PW'(HUND_CYCLES - 1));
      if (!running || tick) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + PW'(1);
      end
   end

   // leap years
   // a two-digit year divisible by four is leap, which holds through 2099
   always_comb begin
      if (t_q[pcs_pkg::REG_YEAR][4]) begin
         leap = (t_q[pcs_pkg::REG_YEAR][3:0] == 4'h2) || (t_q[pcs_pkg::REG_YEAR][3:0] == 4'h6);
      end else begin
         leap = (t_q[pcs_pkg::REG_YEAR][3:0] == 4'h0) || (t_q[pcs_pkg::REG_YEAR][3:0] == 4'h4) ||
                (t_q[pcs_pkg::REG_YEAR][3:0] == 4'h8);
      end
      case (t_q[pcs_pkg::REG_MONTH])
         pcs_pkg::BCD_02: dim = leap ? pcs_pkg::BCD_29 : pcs_pkg::BCD_28;
         pcs_pkg::BCD_04, pcs_pkg::BCD_06, pcs_pkg::BCD_09, pcs_pkg::BCD_11: dim = pcs_pkg::BCD_30;
         default: dim = pcs_pkg::BCD_31;
      endcase
   end

   pcs_bcd_step u_hund (
      .value_i(t_q[pcs_pkg::REG_HUND]), .top_i(pcs_pkg::BCD_99), .low_i(pcs_pkg::BCD_00),
      .next_o(hund_n), .wrap_o(hund_w)
   );
   pcs_bcd_step u_sec (
      .value_i(t_q[pcs_pkg::REG_SEC]), .top_i(pcs_pkg::BCD_59), .low_i(pcs_pkg::BCD_00),
      .next_o(sec_n), .wrap_o(sec_w)
   );
   pcs_bcd_step u_min (
      .value_i(t_q[pcs_pkg::REG_MIN]), .top_i(pcs_pkg::BCD_59), .low_i(pcs_pkg::BCD_00),
      .next_o(min_n), .wrap_o(min_w)
   );
   pcs_bcd_step u_h24 (
      .value_i({2'h0, t_q[pcs_pkg::REG_HOUR][5:0]}), .top_i(pcs_pkg::BCD_23), .low_i(pcs_pkg::BCD_00),
      .next_o(h24_n), .wrap_o(h24_w)
   );
   pcs_bcd_step u_h12 (
      .value_i({3'h0, t_q[pcs_pkg::REG_HOUR][4:0]}), .top_i(pcs_pkg::BCD_12), .low_i(pcs_pkg::BCD_01),
      .next_o(h12_n), .wrap_o(h12_w)
   );
   pcs_bcd_step u_wk (
      .value_i({5'h00, t_q[pcs_pkg::REG_WEEK][2:0]}), .top_i(pcs_pkg::BCD_07), .low_i(pcs_pkg::BCD_01),
      .next_o(wk_n), .wrap_o(wk_w)
   );
   pcs_bcd_step u_date (
      .value_i(t_q[pcs_pkg::REG_DATE]), .top_i(dim), .low_i(pcs_pkg::BCD_01),
      .next_o(date_n), .wrap_o(date_w)
   );
   pcs_bcd_step u_mon (
      .value_i(t_q[pcs_pkg::REG_MONTH]), .top_i(pcs_pkg::BCD_12), .low_i(pcs_pkg::BCD_01),
      .next_o(mon_n), .wrap_o(mon_w)
   );
   pcs_bcd_step u_yr (
      .value_i(t_q[pcs_pkg::REG_YEAR]), .top_i(pcs_pkg::BCD_99), .low_i(pcs_pkg::BCD_00),
      .next_o(yr_n), .wrap_o(yr_w)
   );

   // calendar: a committed transfer wins over a tick in the same cycle
   always_comb begin
      logic carry;
      logic pm;
      logic h11;
      carry = 1'h0;
      pm = 1'h0;
      h11 = 1'h0;
      for (int i = 0; i < pcs_pkg::REG_COUNT; i++) begin
         t_d[i] = t_q[i];
      end
      if (load_q) begin
         for (int i = 0; i < pcs_pkg::REG_COUNT; i++) begin
            t_d[i] = shadow_q[i*8 +: 8] & pcs_pkg::REG_MASK[i*8 +: 8];
         end
      end else if (tick) begin
         t_d[pcs_pkg::REG_HUND] = hund_n;
         if (hund_w) begin
            t_d[pcs_pkg::REG_SEC] = sec_n;
         end
         if (hund_w && sec_w) begin
            t_d[pcs_pkg::REG_MIN] = min_n;
         end
         if (hund_w && sec_w && min_w) begin
            if (t_q[pcs_pkg::REG_HOUR][pcs_pkg::HOUR_MODE_BIT]) begin
               // pm flips at eleven to twelve
               h11 = ({3'h0, t_q[pcs_pkg::REG_HOUR][4:0]} == pcs_pkg::BCD_11);
               pm = t_q[pcs_pkg::REG_HOUR][pcs_pkg::HOUR_PM_BIT] ^ h11;
               carry = t_q[pcs_pkg::REG_HOUR][pcs_pkg::HOUR_PM_BIT] && h11;
               t_d[pcs_pkg::REG_HOUR] = {1'h1, 1'h0, pm, h12_n[4:0]};
            end else begin
               // bit 5 is tens of twenty
               carry = h24_w;
               t_d[pcs_pkg::REG_HOUR] = {2'h0, h24_n[5:0]};
            end
         end
         if (carry) begin
            t_d[pcs_pkg::REG_WEEK] = {t_q[pcs_pkg::REG_WEEK][7:3], wk_n[2:0]};
            t_d[pcs_pkg::REG_DATE] = date_n;
         end
         if (carry && date_w) begin
            t_d[pcs_pkg::REG_MONTH] = mon_n;
         end
         if (carry && date_w && mon_w) begin
            t_d[pcs_pkg::REG_YEAR] = yr_n;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= '0;
         for (int i = 0; i < pcs_pkg::REG_COUNT; i++) begin
            t_q[i] <= pcs_pkg::REG_RESET[i*8 +: 8];
         end
      end else begin
         cnt_q <= cnt_d;
         for (int i = 0; i < pcs_pkg::REG_COUNT; i++) begin
            t_q[i] <= t_d[i];
         end
      end
   end

endmodule

`default_nettype wire

//--- pcs_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// pin-level checks beside pcs_top
module pcs_top_asserts #(
   parameter int unsigned HUND_CYCLES = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic serial_data_bit_i,
   input wire logic reset_n_i,
   input wire logic power_fail_i,
   input wire logic serial_data_bit_o,
   input wire logic serial_data_bit_oe_o,
   input wire logic mem_ce_n_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   // a live read: socket on, output enable, no write, good supply
   logic rd_live;
   assign rd_live = !ce_n_i && !oe_n_i && we_n_i && !power_fail_i;
   chk_mem_follow_ce: assert property (ce_n_i |=> mem_ce_n_o)
      else $error("memory enable low with socket off");
   chk_mem_low_cause: assert property (!mem_ce_n_o |-> $past(!ce_n_i && !power_fail_i))
      else $error("memory enable low without cause");
   chk_pf_mem_off: assert property (power_fail_i |=> mem_ce_n_o)
      else $error("memory enabled during supply fail");
   chk_pf_no_drive: assert property (power_fail_i |=> !serial_data_bit_oe_o)
      else $error("data driven during supply fail");
   chk_drive_stops: assert property (!rd_live |=> !serial_data_bit_oe_o)
      else $error("data driven without read strobe");
   chk_drive_cause: assert property ($rose(serial_data_bit_oe_o) |-> $past(rd_live))
      else $error("drive started without read");
   chk_xfer_inhibit: assert property (serial_data_bit_oe_o |-> mem_ce_n_o)
      else $error("memory enabled during transfer read");
   chk_bit_steady: assert property (serial_data_bit_oe_o [*2] |-> $stable(serial_data_bit_o))
      else $error("data bit changed within a read");
   // drive ends by strobe or pin
   chk_drive_end: assert property ($fell(serial_data_bit_oe_o) |-> $past(!rd_live || !reset_n_i))
      else $error("drive ended without cause");
   cov_xfer_read: cover property ($rose(serial_data_bit_oe_o));
   cov_pf_block: cover property (power_fail_i && !ce_n_i ##1 mem_ce_n_o);
   cov_pass: cover property (!mem_ce_n_o);
endmodule
bind pcs_top pcs_top_asserts #(.HUND_CYCLES(HUND_CYCLES)) u_chk (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .ce_n_i(ce_n_i),
   .oe_n_i(oe_n_i),
   .we_n_i(we_n_i),
   .serial_data_bit_i(serial_data_bit_i),
   .reset_n_i(reset_n_i),
   .power_fail_i(power_fail_i),
   .serial_data_bit_o(serial_data_bit_o),
   .serial_data_bit_oe_o(serial_data_bit_oe_o),
   .mem_ce_n_o(mem_ce_n_o)
);
`default_nettype wire

//--- tb_pcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pcs_top;
   localparam int unsigned HC = 4;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic reset_n = 1'b1;
   logic pfail = 1'b0;
   logic ce_n, oe_n, we_n, sd_in, sd_out, sd_oe, mce_n;
   logic q, oe, m, ok;
   logic [63:0] v;
   int num_errors = 0;
   int tests_run = 0;
   // short tick so rollovers fit in one unlock
   always #50 sys_clk_i = ~sys_clk_i;
   pcs_top #(.HUND_CYCLES(HC)) dut_u (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_n_i(ce_n),
      .oe_n_i(oe_n),
      .we_n_i(we_n),
      .serial_data_bit_i(sd_in),
      .reset_n_i(reset_n),
      .power_fail_i(pfail),
      .serial_data_bit_o(sd_out),
      .serial_data_bit_oe_o(sd_oe),
      .mem_ce_n_o(mce_n)
   );
   pcs_host host_u (
      .clk_i(sys_clk_i),
      .sd_i(sd_out),
      .sd_oe_i(sd_oe),
      .mce_n_i(mce_n),
      .ce_n_o(ce_n),
      .oe_n_o(oe_n),
      .we_n_o(we_n),
      .bus_o(sd_in)
   );
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // bit i lands in register i/8, every bit from the device with memory shut
   task automatic xfer_rd(output logic [63:0] r, output logic good);
      logic b, e, c;
      good = 1'b1;
      host_u.unlock(64, -1);
      for (int i = 0; i < 64; i++) begin
         host_u.rd(1'b0, b, e, c);
         r[i] = b;
         good = good & e & c;
      end
   endtask
   // a few spare edges let the commit land
   task automatic xfer_wr(input logic [63:0] w);
      host_u.unlock(64, -1);
      for (int i = 0; i < 64; i++) host_u.wr(w[i]);
      repeat (3) @(posedge sys_clk_i);
   endtask
   task automatic t_reset();
      xfer_rd(v, ok);
      chk("reset regs", v, pcs_pkg::REG_RESET);
      chk("xfer inhibit", ok, 1'b1);
      host_u.rd(1'b0, q, oe, m);
      chk("pass after xfer", {oe, m}, 2'h0);
   endtask
   task automatic t_pfail();
      pfail = 1'b1;
      host_u.rd(1'b0, q, oe, m);
      chk("pf mem off", m, 1'b1);
      host_u.unlock(64, -1);
      chk("pf write blocked", host_u.wm_q, 1'b1);
      pfail = 1'b0;
      host_u.rd(1'b0, q, oe, m);
      chk("pf unlock", {oe, m}, 2'h0);
   endtask
   task automatic t_miss();
      host_u.unlock(64, 10);
      chk("unlock to mem", host_u.wm_q, 1'b0);
      host_u.rd(1'b0, q, oe, m);
      chk("miss pass", {oe, m}, 2'h0);
   endtask
   // unused bits written high except weekday bit 3, 28 feb 2001 23:59:59 rolls into march
   task automatic t_roll();
      xfer_wr(64'h01E2E8C763D9D990);
      chk("write inhibit", host_u.wm_q, 1'b1);
      xfer_rd(v, ok);
      chk("rollover", v[63:8], 56'h01030101000000);
   endtask
   task automatic t_12h();
      xfer_wr(64'h0102030391595990);
      xfer_rd(v, ok);
      chk("noon pm", v[63:8], 56'h01020303B20000);
   endtask
   // oscillator stopped, reset pin gate open
   task automatic t_abort();
      xfer_wr(64'h0102032321595900);
      xfer_rd(v, ok);
      chk("stopped", v, 64'h0102032321595900);
      host_u.unlock(64, -1);
      for (int i = 0; i < 8; i++) host_u.wr(1'b1);
      @(posedge sys_clk_i);
      #1;
      reset_n = 1'b0;
      @(posedge sys_clk_i);
      #1;
      reset_n = 1'b1;
      for (int i = 0; i < 8; i++) host_u.wr(1'b1);
      xfer_rd(v, ok);
      chk("pin abort", v, 64'h0102032321595900);
   endtask
   task automatic t_rearm();
      host_u.unlock(20, -1);
      xfer_rd(v, ok);
      chk("read rearms", ok, 1'b1);
      chk("still stopped", v, 64'h0102032321595900);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_pfail();
      t_miss();
      t_roll();
      t_12h();
      t_abort();
      t_rearm();
      complete_run();
   end
   // about ten transfers of 300 cycles each fit well inside
   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
